// ---- src/sar_readout_defines.vh ----
// Constants of the converter readout and reset control.
// Assumes a 100 MHz core clock; included by its bare name.
`ifndef SAR_READOUT_DEFINES_VH
`define SAR_READOUT_DEFINES_VH

// Clock period in ns
`define CLK_PERIOD_NS      10
// Conversion time in ns, longest time, cycles round down
`define CONV_TIME_NS       610
`define CONV_CYCLES        (`CONV_TIME_NS / `CLK_PERIOD_NS)
// Resolved bits of the approximation; cycles per bit follow from it
`define BIT_STEPS          16
`define STEP_CYCLES        (`CONV_CYCLES / `BIT_STEPS)
// Sampling start after reset release in ns, cycles round down
`define RELEASE_TIME_NS    20
`define RELEASE_CYCLES     (`RELEASE_TIME_NS / `CLK_PERIOD_NS)
// Abort bound after reset entry in ns (sync plus one state edge fits)
`define ABORT_TIME_NS      50

// Widths
`define RESULT_W           16
`define CNT_W              7
`define BIDX_W             4
`define CNT_ZERO           7'h00
`define CNT_ONE            7'h01
`define BIDX_MSB           4'hF
`define BIDX_ZERO          4'h0

// Result values
`define RESULT_CLEAR       16'h0000
`define TRIAL_START        16'h8000
`define LOW_BYTE_FILL      8'hFF

// Pin synchroniser: {reset_n, convert_start_n, cs_n, rd_n, byte_sel}
`define PIN_W              5
`define PIN_RESET_VAL      5'h1E
`define PIN_RESET_N        4
`define PIN_CONV_N         3
`define PIN_CS_N           2
`define PIN_RD_N           1
`define PIN_BYTE           0

// FIFO shape
`define FIFO_DEPTH         32
`define FIFO_AW            5

`endif

// ---- src/pin_sync.v ----
// Two flip-flop synchroniser for a group of pin inputs.
// Assumes each bit is an independent level from outside the clock domain.
`timescale 1ns/1ps
`include "sar_readout_defines.vh"

module pin_sync
#(
    parameter WIDTH     = `PIN_W,
    parameter RESET_VAL = `PIN_RESET_VAL
)
(
    input  wire             core_clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] pins_in,
    output wire [WIDTH-1:0] pins_out
);

////////////////////////////////////////////////////////////////////////////
// Stage registers
reg [WIDTH-1:0] meta_q;     // First stage, read only by the second
reg [WIDTH-1:0] sync_q;     // Second stage, safe to use

// Two stages, idle levels under reset
always @(posedge core_clk or posedge rst)
begin
    if (rst)
    begin
        meta_q <= RESET_VAL;
        sync_q <= RESET_VAL;
    end
    else
    begin
        meta_q <= pins_in;
        sync_q <= meta_q;
    end
end

assign pins_out = sync_q;

endmodule

// ---- src/word_fifo.v ----
// Synchronous FIFO with valid and ready on both sides and a flush.
// Assumes one clock; flush empties it in one cycle.
`timescale 1ns/1ps
`include "sar_readout_defines.vh"

module word_fifo
#(
    parameter WIDTH = `RESULT_W,
    parameter DEPTH = `FIFO_DEPTH,
    parameter AW    = `FIFO_AW
)
(
    input  wire             core_clk,
    input  wire             rst,
    input  wire             flush,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

////////////////////////////////////////////////////////////////////////////
// Storage and pointers
reg [WIDTH-1:0] mem [0:DEPTH-1];  // Word storage
reg [AW-1:0]    wr_ptr_q;         // Next write slot
reg [AW-1:0]    rd_ptr_q;         // Next read slot
reg [AW:0]      count_q;          // Words held

wire push;                        // Word accepted
wire pop;                         // Word delivered

assign in_ready  = (count_q != DEPTH[AW:0]);
assign out_valid = (count_q != {(AW+1){1'b0}});
assign push      = in_valid & in_ready;
assign pop       = out_valid & out_ready;
assign out_data  = mem[rd_ptr_q];

// Storage write, no reset needed
always @(posedge core_clk)
begin
    if (push)
    begin
        mem[wr_ptr_q] <= in_data;
    end
end

// Pointers and occupancy
always @(posedge core_clk or posedge rst)
begin
    if (rst)
    begin
        wr_ptr_q <= {AW{1'b0}};
        rd_ptr_q <= {AW{1'b0}};
        count_q  <= {(AW+1){1'b0}};
    end
    else if (flush)
    begin
        wr_ptr_q <= {AW{1'b0}};
        rd_ptr_q <= {AW{1'b0}};
        count_q  <= {(AW+1){1'b0}};
    end
    else
    begin
        // Pointers wrap since DEPTH is a power of two
        if (push)
        begin
            wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
        end
        if (pop)
        begin
            rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
        end
        if (push & ~pop)
        begin
            count_q <= count_q + {{AW{1'b0}}, 1'b1};
        end
        else if (pop & ~push)
        begin
            count_q <= count_q - {{AW{1'b0}}, 1'b1};
        end
    end
end

endmodule

// ---- src/sar_readout.v ----
// Readout and reset control of a 16-bit successive approximation converter.
// Assumes an analog core giving a comparator level on core_clk and taking
// the trial code; all control pins come from outside and are synchronised.
//
// Operation
// - Result is unsigned straight binary code
// - Drive data only when select, read low
// - Byte select low: full word on pins
// - Byte select high: low byte up, ones
// - Byte reads work toggled or held read
// - Reset aborts conversion within 50 ns
// - Reset clears output latches to zero
// - Normal operation resumes 20 ns after reset; here it resumes 40 to 50 ns after reset_n rises
// - First sampling starts 20 ns after reset; here 40 to 50 ns after reset_n rises (sync and one state edge first)
// - Sampling starts at later of busy/select fall
// - Busy high from start until conversion done
`timescale 1ns/1ps
`include "sar_readout_defines.vh"

module sar_readout
(
    input  wire                 core_clk,
    input  wire                 rst,
    input  wire                 reset_n,
    input  wire                 convert_start_n,
    input  wire                 cs_n,
    input  wire                 rd_n,
    input  wire                 byte_sel,
    input  wire                 comparator_in,
    output wire [`RESULT_W-1:0] trial_code,
    output wire                 sample_track,
    output wire                 busy,
    output wire [`RESULT_W-1:0] output_data_pins,
    output wire                 output_data_oe_n
);

////////////////////////////////////////////////////////////////////////////
// State codes
localparam ST_RESET   = 3'h0;   // Device reset held
localparam ST_RELEASE = 3'h1;   // Delay after reset release
localparam ST_SAMPLE  = 3'h2;   // Tracking input, waits for start
localparam ST_CONVERT = 3'h3;   // Resolving bits
localparam ST_PUSH    = 3'h4;   // Handing result to the FIFO
localparam ST_DRAIN   = 3'h5;   // Waiting for latch update
localparam ST_WAIT_CS = 3'h6;   // Busy low, waiting for select fall

////////////////////////////////////////////////////////////////////////////
// Functions

// Next trial code after bit idx is decided
function [`RESULT_W-1:0] next_trial;
    input [`RESULT_W-1:0] trial;
    input [`BIDX_W-1:0]   idx;
    input                 keep;
    reg   [`RESULT_W-1:0] t;
    begin
        t = trial;
        // Clear the bit when the input lies below the trial level
        if (!keep)
        begin
            t[idx] = 1'b0;
        end
        // Set the next lower bit as the new trial
        if (idx != `BIDX_ZERO)
        begin
            t[idx - 1'b1] = 1'b1;
        end
        next_trial = t;
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// Pin synchronisation
wire [`PIN_W-1:0] pins_s;       // Synchronised pin levels

pin_sync
#(
    .WIDTH     (`PIN_W),
    .RESET_VAL (`PIN_RESET_VAL)
)
u_pin_sync
(
    .core_clk (core_clk),
    .rst      (rst),
    .pins_in  ({reset_n, convert_start_n, cs_n, rd_n, byte_sel}),
    .pins_out (pins_s)
);

wire reset_n_s   = pins_s[`PIN_RESET_N];  // Device reset, active low
wire conv_n_s    = pins_s[`PIN_CONV_N];   // Convert start, active low
wire cs_n_s      = pins_s[`PIN_CS_N];     // Select, active low
wire rd_n_s      = pins_s[`PIN_RD_N];     // Read strobe, active low
wire byte_s      = pins_s[`PIN_BYTE];     // Half-word select
wire dev_reset   = ~reset_n_s;            // Device reset asserted
wire read_active = ~cs_n_s & ~rd_n_s;     // Output bus enabled

////////////////////////////////////////////////////////////////////////////
// Registers
reg [2:0]            state_q;       // Control state
reg [2:0]            state_d;
reg                  conv_n_prev_q; // Previous convert start level
reg                  busy_q;        // Busy pin
reg                  read_held_q;   // Read strobe held since start
reg [`RESULT_W-1:0]  trial_q;       // Trial code under test
reg [`BIDX_W-1:0]    bit_idx_q;     // Bit under decision
reg                  bits_done_q;   // All bits resolved
reg [`CNT_W-1:0]     step_cnt_q;    // Cycles within one bit
reg [`CNT_W-1:0]     conv_cnt_q;    // Cycles within conversion
reg [`CNT_W-1:0]     rel_cnt_q;     // Cycles since reset release
reg [`RESULT_W-1:0]  latch_q;       // Output data latch
reg [`RESULT_W-1:0]  pins_q;        // Data pin drive

wire conv_fall = conv_n_prev_q & ~conv_n_s;  // Convert start falling
wire start_ok  = conv_fall & ~cs_n_s;        // Valid start, select low

////////////////////////////////////////////////////////////////////////////
// Result FIFO
wire                 fifo_in_valid;  // Result offered
wire                 fifo_in_ready;  // FIFO has room
wire                 fifo_out_valid; // Result waiting for the latch
wire                 fifo_out_ready; // Latch may be updated
wire [`RESULT_W-1:0] fifo_out_data;  // Result leaving the FIFO
wire                 latch_load;     // Latch takes a result

assign fifo_in_valid  = (state_q == ST_PUSH);
// Hold the latch steady during a read pulse; a read held low since
// before the start would otherwise stall the result for ever
assign fifo_out_ready = ~read_active | read_held_q;
assign latch_load     = fifo_out_valid & fifo_out_ready;

word_fifo
#(
    .WIDTH (`RESULT_W),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
)
u_word_fifo
(
    .core_clk  (core_clk),
    .rst       (rst),
    .flush     (dev_reset),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (trial_q),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
);

////////////////////////////////////////////////////////////////////////////
// Next state
always @*
begin
    state_d = state_q;
    if (dev_reset)
    begin
        // Any state, including a conversion, falls to reset
        state_d = ST_RESET;
    end
    else
    begin
        case (state_q)
            ST_RESET:
            begin
                state_d = ST_RELEASE;
            end
            ST_RELEASE:
            begin
                // Fixed delay to first sampling
                if (rel_cnt_q >= `RELEASE_CYCLES - 1)
                begin
                    state_d = ST_SAMPLE;
                end
            end
            ST_SAMPLE:
            begin
                // Hold mode begins on the start edge with select low
                if (start_ok)
                begin
                    state_d = ST_CONVERT;
                end
            end
            ST_CONVERT:
            begin
                if (bits_done_q && (conv_cnt_q >= `CONV_CYCLES - 1))
                begin
                    state_d = ST_PUSH;
                end
            end
            ST_PUSH:
            begin
                // Waits while the FIFO is full
                if (fifo_in_ready)
                begin
                    state_d = ST_DRAIN;
                end
            end
            ST_DRAIN:
            begin
                // Busy falls here; sample now if select is low
                if (latch_load)
                begin
                    state_d = cs_n_s ? ST_WAIT_CS : ST_SAMPLE;
                end
            end
            ST_WAIT_CS:
            begin
                // Select fall comes after busy fall
                if (!cs_n_s)
                begin
                    state_d = ST_SAMPLE;
                end
            end
            default:
            begin
                state_d = ST_RESET;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////
// Control and approximation registers
always @(posedge core_clk or posedge rst)
begin
    if (rst)
    begin
        state_q       <= ST_RESET;
        conv_n_prev_q <= 1'b1;
        busy_q        <= 1'b0;
        read_held_q   <= 1'b0;
        trial_q       <= `RESULT_CLEAR;
        bit_idx_q     <= `BIDX_MSB;
        bits_done_q   <= 1'b0;
        step_cnt_q    <= `CNT_ZERO;
        conv_cnt_q    <= `CNT_ZERO;
        rel_cnt_q     <= `CNT_ZERO;
    end
    else
    begin
        state_q       <= state_d;
        conv_n_prev_q <= conv_n_s;
        // Release delay counter, cleared outside the release delay
        rel_cnt_q <= (state_q == ST_RELEASE) ? rel_cnt_q + `CNT_ONE : `CNT_ZERO;
        // Read held low since the start stays exempt until released
        read_held_q <= read_active & (read_held_q | ((state_q == ST_SAMPLE) & start_ok));
        if (dev_reset)
        begin
            // Abort the conversion and drop busy
            busy_q      <= 1'b0;
            bits_done_q <= 1'b0;
            step_cnt_q  <= `CNT_ZERO;
            conv_cnt_q  <= `CNT_ZERO;
        end
        else if ((state_q == ST_SAMPLE) && start_ok)
        begin
            // Start: busy high, first trial at mid scale
            busy_q      <= 1'b1;
            trial_q     <= `TRIAL_START;
            bit_idx_q   <= `BIDX_MSB;
            bits_done_q <= 1'b0;
            step_cnt_q  <= `CNT_ZERO;
            conv_cnt_q  <= `CNT_ZERO;
        end
        else if (state_q == ST_CONVERT)
        begin
            conv_cnt_q <= conv_cnt_q + `CNT_ONE;
            if (!bits_done_q)
            begin
                if (step_cnt_q >= `STEP_CYCLES - 1)
                begin
                    // Decide one bit, most significant first
                    step_cnt_q <= `CNT_ZERO;
                    trial_q    <= next_trial(trial_q, bit_idx_q, comparator_in);
                    if (bit_idx_q == `BIDX_ZERO)
                    begin
                        bits_done_q <= 1'b1;
                    end
                    else
                    begin
                        bit_idx_q <= bit_idx_q - 1'b1;
                    end
                end
                else
                begin
                    step_cnt_q <= step_cnt_q + `CNT_ONE;
                end
            end
        end
        else if ((state_q == ST_DRAIN) && latch_load)
        begin
            // Result now readable, conversion ended
            busy_q <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// Output latch and data pins
always @(posedge core_clk or posedge rst)
begin
    if (rst)
    begin
        latch_q <= `RESULT_CLEAR;
        pins_q  <= `RESULT_CLEAR;
    end
    else if (dev_reset)
    begin
        // Latches read as zero until a new result arrives
        latch_q <= `RESULT_CLEAR;
        pins_q  <= `RESULT_CLEAR;
    end
    else
    begin
        if (latch_load)
        begin
            latch_q <= fifo_out_data;
        end
        // Pins follow the byte select level continuously
        pins_q <= byte_s ? {latch_q[7:0], `LOW_BYTE_FILL} : latch_q;
    end
end

// Drive only with select and read both low
assign output_data_oe_n = ~read_active;
assign output_data_pins = pins_q;
assign busy             = busy_q;
assign trial_code       = trial_q;
assign sample_track     = (state_q == ST_SAMPLE);

endmodule

// ---- tb/sar_readout_sva.sv ----
// Concurrent checks on the converter readout pins.
// Assumes a bind onto sar_readout; sees only its ports.
`timescale 1ns/1ps
`include "sar_readout_defines.vh"

module sar_readout_sva
(
    input wire logic                 core_clk,
    input wire logic                 rst,
    input wire logic                 reset_n,
    input wire logic                 convert_start_n,
    input wire logic                 cs_n,
    input wire logic                 rd_n,
    input wire logic                 byte_sel,
    input wire logic                 comparator_in,
    input wire logic [`RESULT_W-1:0] trial_code,
    input wire logic                 sample_track,
    input wire logic                 busy,
    input wire logic [`RESULT_W-1:0] output_data_pins,
    input wire logic                 output_data_oe_n
);
    logic [7:0] busy_len_q; // Cycles the present busy span has lasted

    ////////////////////////////////////////////////////////////////////////////////
    // Busy span counter, saturating so a stuck busy cannot wrap
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            busy_len_q <= 8'h00;
        else if (!busy)
            busy_len_q <= 8'h00;
        else if (busy_len_q != 8'hFF)
            busy_len_q <= busy_len_q + 8'h01;
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Host holds select and read low across the pin synchroniser
    sequence s_read_held;
        (!cs_n && !rd_n) [*3];
    endsequence
    // Reset pin held low long enough to reach the state logic
    sequence s_reset_held;
        (!reset_n) [*5];
    endsequence

    a_oe_needs_read: assert property (!output_data_oe_n |-> !$past(cs_n, 2) && !$past(rd_n, 2))
        else $error("Data pins driven without select and read");
    a_oe_on_read: assert property (s_read_held |-> !output_data_oe_n)
        else $error("Data pins not driven during a read");
    a_busy_cause: assert property ($rose(busy) |-> !$past(convert_start_n, 3) && !$past(cs_n, 3))
        else $error("Busy rose without a selected start");
    a_busy_length: assert property ($fell(busy) && reset_n |-> busy_len_q >= 8'h3D)
        else $error("Busy fell before the conversion time");
    a_busy_bound: assert property ($rose(busy) |-> ##[61:120] !busy)
        else $error("Conversion did not complete in time");
    a_no_sample_busy: assert property (busy |-> !sample_track)
        else $error("Sampling while busy");
    a_sample_after_busy: assert property ($fell(busy) && reset_n && !$past(cs_n, 3)
        |-> ##[0:3] sample_track)
        else $error("Sampling did not follow busy fall");
    a_no_early_sample: assert property ($rose(sample_track) && $past(reset_n, 8)
        |-> !$past(cs_n, 3))
        else $error("Sampling began before select fell");
    a_abort_reset: assert property (s_reset_held |-> !busy)
        else $error("Conversion not aborted by reset");
    a_clear_latch: assert property (s_reset_held ##1 !reset_n |-> output_data_pins == 16'h0000)
        else $error("Output latch not cleared by reset");
    a_first_sample: assert property ($rose(reset_n) |-> ##[1:8] sample_track)
        else $error("First sampling late after reset");
    a_low_byte_fill: assert property (!output_data_oe_n && $past(byte_sel, 3) && $past(byte_sel, 4)
        |-> output_data_pins[7:0] == 8'hFF)
        else $error("Lower pins not all ones in byte mode");
endmodule

// ---- tb/host_side_model.sv ----
// Far-side model: analog front end and the host's view of the data bus.
// Assumes the bench sets analog_code while the converter samples.
`timescale 1ns/1ps

module host_side_model
(
    input  wire logic        core_clk,
    input  wire logic [15:0] analog_code,
    input  wire logic [15:0] trial_code,
    input  wire logic [15:0] output_data_pins,
    input  wire logic        output_data_oe_n,
    output logic             comparator_in,
    output wire logic [15:0] host_bus
);
    logic [15:0] last_q = 16'h0000; // Last value driven onto the bus

    initial comparator_in = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // Keep-bit decision for the present trial, moved off the rising edge
    always @(negedge core_clk)
        comparator_in <= (analog_code >= trial_code);

    // Remember the driven value so a released bus can show its inverse
    always @(negedge core_clk)
        if (!output_data_oe_n)
            last_q <= output_data_pins;

    // No pull on the bus: a released bus reads as the inverse of the last value
    assign host_bus = output_data_oe_n ? ~last_q : output_data_pins;
endmodule

// ---- tb/sar_readout_tb_top.sv ----
// Self-checking bench for the converter readout and reset control.
// Assumes host_side_model stands in for the analog core and the host bus.
`timescale 1ns/1ps
`include "sar_readout_defines.vh"

module sar_readout_tb_top;
    logic        core_clk = 1'b0;        // 100 MHz clock
    logic        rst = 1'b1;             // Block reset
    logic        reset_n = 1'b1;         // Device reset pin
    logic        convert_start_n = 1'b1; // Start pin
    logic        cs_n = 1'b1;            // Select pin
    logic        rd_n = 1'b1;            // Read strobe
    logic        byte_sel = 1'b0;        // Half-word select
    logic        sel_after_start = 1'b1; // Select level left after a start
    logic [15:0] analog_code = 16'h0000; // Input level as an ideal code
    wire         comparator_in, sample_track, busy, output_data_oe_n;
    wire  [15:0] trial_code, output_data_pins, host_bus;
    int          mismatches = 0;
    int          total_checks = 0;

    always #5 core_clk = ~core_clk;

    sar_readout u_sar_readout (.core_clk(core_clk), .rst(rst), .reset_n(reset_n),
        .convert_start_n(convert_start_n), .cs_n(cs_n), .rd_n(rd_n), .byte_sel(byte_sel),
        .comparator_in(comparator_in), .trial_code(trial_code), .sample_track(sample_track),
        .busy(busy), .output_data_pins(output_data_pins), .output_data_oe_n(output_data_oe_n));

    host_side_model u_host_side_model (.core_clk(core_clk), .analog_code(analog_code),
        .trial_code(trial_code), .output_data_pins(output_data_pins),
        .output_data_oe_n(output_data_oe_n), .comparator_in(comparator_in), .host_bus(host_bus));

    ////////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Bounded wait for busy or sampling to reach a level
    task automatic wait_on(input bit on_busy, input logic lvl);
        int n;
        n = 0;
        while ((on_busy ? busy : sample_track) !== lvl && n < 300)
        begin
            @(negedge core_clk);
            n++;
        end
        check({15'h0000, on_busy ? busy : sample_track}, {15'h0000, lvl});
    endtask

    // One full conversion; select falls first so sampling can begin
    task automatic convert(input logic [15:0] level);
        analog_code = level;
        @(negedge core_clk);
        cs_n = 1'b0;
        wait_on(1'b0, 1'b1);
        repeat (2) @(negedge core_clk);
        convert_start_n = 1'b0;
        repeat (4) @(negedge core_clk);
        convert_start_n = 1'b1;
        cs_n = sel_after_start;
        wait_on(1'b1, 1'b1);
        wait_on(1'b1, 1'b0);
        repeat (2) @(negedge core_clk);
    endtask

    // Select alone, then a read, then release
    task automatic read_word(input logic sel, input logic [15:0] exp);
        @(negedge core_clk);
        byte_sel = sel;
        cs_n = 1'b0;
        repeat (4) @(negedge core_clk);
        check({15'h0000, output_data_oe_n}, 16'h0001);
        rd_n = 1'b0;
        repeat (4) @(negedge core_clk);
        check({15'h0000, output_data_oe_n}, 16'h0000);
        check(host_bus, exp);
        rd_n = 1'b1;
        cs_n = 1'b1;
        repeat (4) @(negedge core_clk);
        check({15'h0000, output_data_oe_n}, 16'h0001);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Code table corners, word read and one byte read each
    task automatic sc_codes;
        logic [15:0] codes [4];
        codes = '{16'hFFFF, 16'h8000, 16'h7FFF, 16'h0000};
        foreach (codes[i])
        begin
            convert(codes[i]);
            read_word(1'b0, codes[i]);
            read_word(1'b1, {codes[i][7:0], 8'hFF});
        end
    endtask

    // Read strobe held low while the half-word select toggles
    task automatic sc_held;
        sel_after_start = 1'b0;
        byte_sel = 1'b0;
        convert(16'hA5C3);
        sel_after_start = 1'b1;
        @(negedge core_clk);
        cs_n = 1'b0;
        rd_n = 1'b0;
        repeat (4) @(negedge core_clk);
        check(host_bus, 16'hA5C3);
        byte_sel = 1'b1;
        repeat (4) @(negedge core_clk);
        check(host_bus, 16'hC3FF);
        byte_sel = 1'b0;
        repeat (4) @(negedge core_clk);
        check(host_bus, 16'hA5C3);
        rd_n = 1'b1;
        cs_n = 1'b1;
    endtask

    // Start with select high is ignored
    task automatic sc_refuse;
        wait_on(1'b0, 1'b1);
        @(negedge core_clk);
        convert_start_n = 1'b0;
        repeat (4) @(negedge core_clk);
        convert_start_n = 1'b1;
        repeat (6) @(negedge core_clk);
        check({15'h0000, busy}, 16'h0000);
    endtask

    // Reset in mid-conversion, then a clean conversion
    task automatic sc_reset;
        convert(16'h5A3C);
        @(negedge core_clk);
        cs_n = 1'b0;
        wait_on(1'b0, 1'b1);
        repeat (2) @(negedge core_clk);
        convert_start_n = 1'b0;
        repeat (4) @(negedge core_clk);
        convert_start_n = 1'b1;
        cs_n = 1'b1;
        repeat (20) @(negedge core_clk);
        check({15'h0000, busy}, 16'h0001);
        reset_n = 1'b0;
        repeat (6) @(negedge core_clk);
        check({15'h0000, busy}, 16'h0000);
        reset_n = 1'b1;
        wait_on(1'b0, 1'b1);
        read_word(1'b0, 16'h0000);
        convert(16'h1234);
        read_word(1'b0, 16'h1234);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Main sequence: power-up pulse and three settling conversions first
    initial
    begin
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        reset_n = 1'b0;
        repeat (3) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (3) convert(16'h0000);
        sc_codes();
        sc_held();
        sc_refuse();
        sc_reset();
        end_of_test();
    end

    // Watchdog against a hang
    initial
    begin
        #100000;
        mismatches++;
        $display("[FAIL] %0t watchdog got %h expected %h", $time, 1'b0, 1'b1);
        end_of_test();
    end
endmodule

bind sar_readout sar_readout_sva u_sar_readout_sva (.core_clk(core_clk), .rst(rst),
    .reset_n(reset_n), .convert_start_n(convert_start_n), .cs_n(cs_n), .rd_n(rd_n),
    .byte_sel(byte_sel), .comparator_in(comparator_in), .trial_code(trial_code),
    .sample_track(sample_track), .busy(busy), .output_data_pins(output_data_pins),
    .output_data_oe_n(output_data_oe_n));
